// ===== core/dpf_pkg.sv
// Constants, field layouts and carrier types of the datapath FIFO/ALU block
package dpf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned FIFO_DEPTH_DEF = 4;
  localparam int unsigned FIFO_NUM       = 2;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned IRQ_W          = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG_OFS = 8'h00;
  localparam logic [7:0] REG_FIFO0_OFS  = 8'h04;
  localparam logic [7:0] REG_FIFO1_OFS  = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_IRQSTA_OFS = 8'h10;
  localparam logic [7:0] REG_IRQMSK_OFS = 8'h14;
  localparam logic [7:0] REG_ACC0_OFS   = 8'h18;
  localparam logic [7:0] REG_ACC1_OFS   = 8'h1C;
  localparam logic [7:0] REG_DREG_OFS   = 8'h20;

  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_CLKINV_POS = 0;
  localparam int unsigned CFG_DYN_POS    = 2;
  localparam int unsigned CFG_INSEL0_POS = 4;
  localparam int unsigned CFG_INSEL1_POS = 6;
  localparam int unsigned CFG_LVL_POS    = 8;
  localparam int unsigned CFG_CISELA_POS = 10;
  localparam int unsigned CFG_CISELB_POS = 12;
  localparam int unsigned CFG_MSB_POS    = 14;
  localparam logic [31:0] CFG_RST        = 32'h0001_C000;

  // ----------------------------------------------------------------
  // Status word and interrupt bits
  // ----------------------------------------------------------------
  localparam int unsigned STA_BLK_POS   = 0;
  localparam int unsigned STA_BUS_POS   = 2;
  localparam int unsigned STA_CARRY_POS = 4;
  localparam int unsigned IRQ_BLK_POS   = 0;
  localparam int unsigned IRQ_BUS_POS   = 2;
  localparam int unsigned IRQ_CARRY_POS = 4;
  localparam logic [4:0]  IRQ_MSK_RST   = 5'h00;

  // ----------------------------------------------------------------
  // Fixed ALU operands and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPB_INC = 8'h00;
  localparam logic [7:0] OPB_DEC = 8'hFF;
  localparam logic [7:0] ACC_RST = 8'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_PASS = 3'b000, ALU_INC = 3'b001, ALU_DEC = 3'b010,
    ALU_ADD  = 3'b011, ALU_SUB = 3'b100, ALU_XOR = 3'b101,
    ALU_AND  = 3'b110, ALU_OR  = 3'b111
  } dpf_alu_e;

  typedef enum logic [1:0] {
    CI_DEFAULT = 2'b00, CI_REGISTERED = 2'b01,
    CI_ROUTED  = 2'b10, CI_CHAINED    = 2'b11
  } dpf_ci_e;

  typedef enum logic [1:0] {
    SRC_BUS = 2'b00, SRC_ACC0 = 2'b01, SRC_ACC1 = 2'b10, SRC_ALU = 2'b11
  } dpf_src_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] msbPos;
    dpf_ci_e    ciSelB;
    dpf_ci_e    ciSelA;
    logic [1:0] levelSel;
    dpf_src_e   writeSrc1;
    dpf_src_e   writeSrc0;
    logic [1:0] dirDynamic;
    logic [1:0] clockInvert;
  } dpf_cfg_s;

  typedef struct packed {
    dpf_alu_e   aluFunc;
    logic       ciUseB;
    logic [1:0] accWrite;
    logic [1:0] fifoLoad;
    logic [1:0] fifoToAcc;
    logic [1:0] dataRegLoad;
    logic       carryRouted;
    logic       carryChained;
  } dpf_route_s;

endpackage

// ===== core/dpf_datapath.sv
// Datapath FIFO pair with dynamic direction, ALU with carry, Avalon slave
`timescale 1ns/1ps
`default_nettype none

module dpf_datapath
  import dpf_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Routed control and chained carry
  input  wire dpf_route_s        route,
  // Datapath outputs
  output logic [1:0]             fifoBlockSideStatus,
  output logic [1:0]             fifoBusSideStatus,
  output logic                   carryOut,
  output logic [DATA_W-1:0]      aluResult,
  output logic                   irq
);

  localparam int unsigned PTR_W = $clog2(FIFO_DEPTH);
  localparam int unsigned CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(FIFO_DEPTH / 2);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Pointers wrap naturally only at a power of two
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : gBad
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Status pair {block, bus}; output meaning applies in dynamic mode
  function automatic logic [1:0] fifoStatus(input logic [CNT_W-1:0] cnt,
                                            input logic outMode,
                                            input logic lvl);
    logic [1:0] st;
    st = 2'b00;
    if (outMode) begin
      st[1] = (cnt == DEPTH_C);
      st[0] = lvl ? (cnt >= HALF_C) : (cnt != '0);
    end else begin
      st[1] = (cnt == '0);
      st[0] = lvl ? ((DEPTH_C - cnt) >= HALF_C) : (cnt != DEPTH_C);
    end
    return st;
  endfunction

  // Raw adder carry out of the programmed MSB position
  function automatic logic msbCarry(input logic [7:0] a,
                                    input logic [7:0] b,
                                    input logic ci,
                                    input logic [2:0] m);
    logic [7:0] mask;
    logic [8:0] sum;
    mask = 8'hFF >> (3'd7 - m);
    sum  = {1'b0, a & mask} + {1'b0, b & mask} + {8'h00, ci};
    return sum[{1'b0, m} + 4'd1];
  endfunction

  // ----------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------
  dpf_cfg_s          cfg_q;
  logic [31:0]       readdata_q;
  logic              waitReq_q;
  logic [7:0]        acc_q [FIFO_NUM];
  logic [7:0]        dataReg_q [FIFO_NUM];
  logic [1:0]        loadPrev_q;
  logic              carryFlag_q;
  logic [7:0]        aluResult_q;
  logic [1:0]        blkStat_q;
  logic [1:0]        busStat_q;
  logic [IRQ_W-1:0]  irqSta_q;
  logic [IRQ_W-1:0]  irqMsk_q;
  logic              irq_q;

  logic              busRdDone;
  logic              busWrDone;
  logic [1:0]        fifoClk;
  logic [1:0]        push;
  logic [1:0]        pop;
  logic [7:0]        pushData [FIFO_NUM];
  logic [7:0]        fifoHead [FIFO_NUM];
  logic [CNT_W-1:0]  fifoCnt [FIFO_NUM];
  logic [1:0]        busWrOk;
  logic [1:0]        busRdOk;
  logic [1:0]        dpWrOk;
  logic [1:0]        dpRdOk;
  logic [1:0]        dregLoad;
  logic [1:0]        blkStat_d;
  logic [1:0]        busStat_d;
  logic [7:0]        aluRes_d;
  logic              carry_d;
  logic [IRQ_W-1:0]  irqEvt;

  // Transfer completes at the edge where waitrequest is seen low
  assign busRdDone = read && !waitReq_q;
  assign busWrDone = write && !waitReq_q;

  // ----------------------------------------------------------------
  // Avalon handshake: one wait cycle per access
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= !((read || write) && waitReq_q);
    end
  end

  // Configuration register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q.clockInvert <= CFG_RST[CFG_CLKINV_POS +: 2];
      cfg_q.dirDynamic  <= CFG_RST[CFG_DYN_POS +: 2];
      cfg_q.writeSrc0   <= dpf_src_e'(CFG_RST[CFG_INSEL0_POS +: 2]);
      cfg_q.writeSrc1   <= dpf_src_e'(CFG_RST[CFG_INSEL1_POS +: 2]);
      cfg_q.levelSel    <= CFG_RST[CFG_LVL_POS +: 2];
      cfg_q.ciSelA      <= dpf_ci_e'(CFG_RST[CFG_CISELA_POS +: 2]);
      cfg_q.ciSelB      <= dpf_ci_e'(CFG_RST[CFG_CISELB_POS +: 2]);
      cfg_q.msbPos      <= CFG_RST[CFG_MSB_POS +: 3];
    end else if (busWrDone && address == REG_CONFIG_OFS) begin
      cfg_q.clockInvert <= writedata[CFG_CLKINV_POS +: 2];
      cfg_q.dirDynamic  <= writedata[CFG_DYN_POS +: 2];
      cfg_q.writeSrc0   <= dpf_src_e'(writedata[CFG_INSEL0_POS +: 2]);
      cfg_q.writeSrc1   <= dpf_src_e'(writedata[CFG_INSEL1_POS +: 2]);
      cfg_q.levelSel    <= writedata[CFG_LVL_POS +: 2];
      cfg_q.ciSelA      <= dpf_ci_e'(writedata[CFG_CISELA_POS +: 2]);
      cfg_q.ciSelB      <= dpf_ci_e'(writedata[CFG_CISELB_POS +: 2]);
      cfg_q.msbPos      <= writedata[CFG_MSB_POS +: 3];
    end
  end

  // Read data captured in the wait cycle, stands at the done edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && waitReq_q) begin
      case (address)
        REG_CONFIG_OFS: readdata_q <= {15'h0000, cfg_q};
        REG_FIFO0_OFS:  readdata_q <= {24'h00_0000, fifoHead[0]};
        REG_FIFO1_OFS:  readdata_q <= {24'h00_0000, fifoHead[1]};
        REG_STATUS_OFS: readdata_q <= {27'h000_0000, carryFlag_q,
                                       busStat_q, blkStat_q};
        REG_IRQSTA_OFS: readdata_q <= {27'h000_0000, irqSta_q};
        REG_IRQMSK_OFS: readdata_q <= {27'h000_0000, irqMsk_q};
        REG_ACC0_OFS:   readdata_q <= {24'h00_0000, acc_q[0]};
        REG_ACC1_OFS:   readdata_q <= {24'h00_0000, acc_q[1]};
        REG_DREG_OFS:   readdata_q <= {16'h0000, dataReg_q[1],
                                       dataReg_q[0]};
        default:        readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // FIFO access steering
  // ----------------------------------------------------------------
  // Static: source code 0 is input mode, others output mode
  always_comb begin
    for (int i = 0; i < FIFO_NUM; i++) begin
      logic outMode;
      logic extSide;
      outMode = ((i == 0) ? cfg_q.writeSrc0 : cfg_q.writeSrc1) != SRC_BUS;
      extSide = route.dataRegLoad[i];
      if (cfg_q.dirDynamic[i]) begin
        busWrOk[i]  = extSide;
        busRdOk[i]  = extSide;
        dpWrOk[i]   = !extSide && outMode;
        dpRdOk[i]   = !extSide;
        dregLoad[i] = 1'b0;
      end else begin
        busWrOk[i]  = !outMode;
        busRdOk[i]  = outMode;
        dpWrOk[i]   = outMode;
        dpRdOk[i]   = !outMode;
        dregLoad[i] = !outMode && extSide && !loadPrev_q[i];
      end
      {blkStat_d[i], busStat_d[i]} =
        fifoStatus(fifoCnt[i], outMode || cfg_q.dirDynamic[i],
                   cfg_q.levelSel[i]);
    end
  end

  // Push and pop requests; bus write wins a same-cycle collision
  always_comb begin
    for (int i = 0; i < FIFO_NUM; i++) begin
      logic busHit;
      dpf_src_e src;
      busHit = address == ((i == 0) ? REG_FIFO0_OFS : REG_FIFO1_OFS);
      src    = (i == 0) ? cfg_q.writeSrc0 : cfg_q.writeSrc1;
      push[i] = (busWrDone && busHit && busWrOk[i]) ||
                (route.fifoLoad[i] && dpWrOk[i]);
      case (src)
        SRC_ACC0: pushData[i] = acc_q[0];
        SRC_ACC1: pushData[i] = acc_q[1];
        SRC_ALU:  pushData[i] = aluRes_d;
        default:  pushData[i] = 8'h00;
      endcase
      if (busWrDone && busHit && busWrOk[i]) begin
        pushData[i] = writedata[7:0];
      end
      pop[i] = (busRdDone && busHit && busRdOk[i]) ||
               (route.fifoToAcc[i] && dpRdOk[i]) || dregLoad[i];
    end
  end

  // ----------------------------------------------------------------
  // FIFO storage, one clock domain per polarity setting
  // ----------------------------------------------------------------
  // Change the invert bit only while the FIFO is idle
  for (genvar g = 0; g < FIFO_NUM; g++) begin : gFifo
    logic [7:0]       mem_q [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] cnt_q;
    logic             doPop;

    assign fifoClk[g]  = core_clk ^ cfg_q.clockInvert[g];
    assign fifoHead[g] = mem_q[rdPtr_q];
    assign fifoCnt[g]  = cnt_q;
    // Underflow reads are ignored, pointers stay put
    assign doPop       = pop[g] && (cnt_q != '0);

    // Data array
    always_ff @(posedge fifoClk[g]) begin
      if (push[g]) begin
        mem_q[wrPtr_q] <= pushData[g];
      end
    end

    // Pointers and level; overflow overwrites the front entry
    always_ff @(posedge fifoClk[g] or negedge reset_n) begin
      if (!reset_n) begin
        wrPtr_q <= '0;
        rdPtr_q <= '0;
        cnt_q   <= '0;
      end else begin
        if (push[g]) begin
          wrPtr_q <= wrPtr_q + PTR_W'(1);
        end
        if (doPop || (push[g] && cnt_q == DEPTH_C)) begin
          rdPtr_q <= rdPtr_q + PTR_W'(1);
        end
        if (push[g] && !doPop && cnt_q != DEPTH_C) begin
          cnt_q <= cnt_q + CNT_W'(1);
        end else if (doPop && !push[g]) begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers and accumulators
  // ----------------------------------------------------------------
  // Load inputs are edge sensitive in static mode
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loadPrev_q   <= 2'b00;
      dataReg_q[0] <= ACC_RST;
      dataReg_q[1] <= ACC_RST;
    end else begin
      loadPrev_q <= route.dataRegLoad;
      for (int i = 0; i < FIFO_NUM; i++) begin
        if (dregLoad[i]) begin
          dataReg_q[i] <= fifoHead[i];
        end
      end
    end
  end

  // FIFO read beats ALU result, which beats a bus write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q[0] <= ACC_RST;
      acc_q[1] <= ACC_RST;
    end else begin
      for (int i = 0; i < FIFO_NUM; i++) begin
        if (route.fifoToAcc[i] && dpRdOk[i]) begin
          acc_q[i] <= fifoHead[i];
        end else if (route.accWrite[i]) begin
          acc_q[i] <= aluRes_d;
        end else if (busWrDone &&
                     address == ((i == 0) ? REG_ACC0_OFS : REG_ACC1_OFS)) begin
          acc_q[i] <= writedata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // ALU: source A is accumulator 0, source B accumulator 1
  // ----------------------------------------------------------------
  // Shifter and mask stages sit downstream and are not built here
  always_comb begin
    dpf_ci_e    ciSel;
    logic       rawCi;
    logic       ci;
    logic       inverted;
    logic [7:0] opB;
    rawCi = 1'b0;
    ciSel = route.ciUseB ? cfg_q.ciSelB : cfg_q.ciSelA;
    inverted = (route.aluFunc == ALU_DEC) || (route.aluFunc == ALU_SUB);
    case (ciSel)
      CI_REGISTERED: rawCi = carryFlag_q;
      CI_ROUTED:     rawCi = route.carryRouted;
      CI_CHAINED:    rawCi = route.carryChained;
      default:       rawCi = 1'b0;
    endcase
    ci = inverted ? !rawCi : rawCi;
    opB = acc_q[1];
    // default carry and operand per function
    case (route.aluFunc)
      ALU_INC: begin
        opB = OPB_INC;
        if (ciSel == CI_DEFAULT) ci = 1'b1;
      end
      ALU_DEC: begin
        opB = OPB_DEC;
        if (ciSel == CI_DEFAULT) ci = 1'b0;
      end
      ALU_ADD: begin
        if (ciSel == CI_DEFAULT) ci = 1'b0;
      end
      ALU_SUB: begin
        opB = ~acc_q[1];
        if (ciSel == CI_DEFAULT) ci = 1'b1;
      end
      default: ci = 1'b0;
    endcase
    case (route.aluFunc)
      ALU_PASS: aluRes_d = acc_q[0];
      ALU_XOR:  aluRes_d = acc_q[0] ^ acc_q[1];
      ALU_AND:  aluRes_d = acc_q[0] & acc_q[1];
      ALU_OR:   aluRes_d = acc_q[0] | acc_q[1];
      default:  aluRes_d = acc_q[0] + opB + {7'h00, ci};
    endcase
    // inverted carry out for subtractive ops
    case (route.aluFunc)
      ALU_INC, ALU_ADD: carry_d = msbCarry(acc_q[0], opB, ci, cfg_q.msbPos);
      ALU_DEC, ALU_SUB: carry_d = !msbCarry(acc_q[0], opB, ci, cfg_q.msbPos);
      default:          carry_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      carryFlag_q <= 1'b0;
      aluResult_q <= 8'h00;
    end else begin
      carryFlag_q <= carry_d;
      aluResult_q <= aluRes_d;
    end
  end

  // ----------------------------------------------------------------
  // Status registers and interrupts
  // ----------------------------------------------------------------
  // Rising status edges and a new carry raise events
  assign irqEvt = {carry_d & ~carryFlag_q,
                   busStat_d & ~busStat_q,
                   blkStat_d & ~blkStat_q};

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      blkStat_q <= 2'b00;
      busStat_q <= 2'b00;
      irqSta_q  <= '0;
      irqMsk_q  <= IRQ_MSK_RST;
      irq_q     <= 1'b0;
    end else begin
      blkStat_q <= blkStat_d;
      busStat_q <= busStat_d;
      if (busWrDone && address == REG_IRQSTA_OFS) begin
        irqSta_q <= (irqSta_q & ~writedata[IRQ_W-1:0]) | irqEvt;
      end else begin
        irqSta_q <= irqSta_q | irqEvt;
      end
      if (busWrDone && address == REG_IRQMSK_OFS) begin
        irqMsk_q <= writedata[IRQ_W-1:0];
      end
      irq_q <= |(irqSta_q & irqMsk_q);
    end
  end

  // Outputs straight from flip-flops
  assign readdata            = readdata_q;
  assign waitrequest         = waitReq_q;
  assign fifoBlockSideStatus = blkStat_q;
  assign fifoBusSideStatus   = busStat_q;
  assign carryOut            = carryFlag_q;
  assign aluResult           = aluResult_q;
  assign irq                 = irq_q;

endmodule

`default_nettype wire

// ===== bench/dpf_checker_asserts.sv
// Checker of bus handshake and carry-out relations of the datapath
`timescale 1ns/1ps
`default_nettype none
module dpf_checker
  import dpf_pkg::*;
(
  // Clock, reset and bus
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic              waitrequest,
  // Routed control and results
  input wire dpf_route_s        route,
  input wire logic [DATA_W-1:0] aluResult,
  input wire logic              carryOut
);
  logic [31:0] cfgQ;
  logic        dflt;
  logic        rtd;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Config shadow, since the carry mode is not visible at the ports
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cfgQ <= CFG_RST;
    else if (write && !waitrequest && address == REG_CONFIG_OFS)
      cfgQ <= writedata;
  end
  // Carry mode A active with full-width MSB
  assign dflt = !route.ciUseB && cfgQ[16:14] == 3'b111 &&
                cfgQ[11:10] == 2'b00;
  assign rtd  = !route.ciUseB && cfgQ[16:14] == 3'b111 &&
                cfgQ[11:10] == 2'b10;
  wait_pulse_a: assert property (
    !waitrequest |=> waitrequest) else $error("wait low too long");
  wait_answer_a: assert property (
    $rose(read || write) |=> !waitrequest) else $error("no bus answer");
  wait_idle_a: assert property (
    !(read || write) |=> waitrequest) else $error("answer without request");
  logic_carry_a: assert property (
    route.aluFunc inside {ALU_PASS, ALU_XOR, ALU_AND, ALU_OR} |=> !carryOut)
    else $error("carry from logic function");
  inc_wrap_a: assert property (
    dflt && route.aluFunc == ALU_INC |=> carryOut == (aluResult == 8'h00))
    else $error("increment carry wrong");
  dec_borrow_a: assert property (
    dflt && route.aluFunc == ALU_DEC |=> carryOut == (aluResult == 8'hFF))
    else $error("decrement carry wrong");
  inc_routed_a: assert property (
    rtd && route.aluFunc == ALU_INC |=>
    carryOut == ($past(route.carryRouted) && aluResult == 8'h00))
    else $error("routed increment carry wrong");
  dec_routed_a: assert property (
    rtd && route.aluFunc == ALU_DEC |=>
    carryOut == ($past(route.carryRouted) && aluResult == 8'hFF))
    else $error("routed decrement carry wrong");
endmodule
bind dpf_datapath dpf_checker chk_u (.core_clk(core_clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .waitrequest(waitrequest), .route(route), .aluResult(aluResult),
  .carryOut(carryOut));
`default_nettype wire

// ===== bench/dpf_nbr_model.sv
// Neighbouring datapath model supplying a chained carry
`timescale 1ns/1ps
`default_nettype none
module dpf_nbr_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Chained carry toward this block
  output logic     carryQ
);
  // Toggles each cycle so a stale carry is told from a fresh one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) carryQ <= 1'b0;
    else carryQ <= ~carryQ;
  end
endmodule
`default_nettype wire

// ===== bench/dpf_datapath_bench.sv
// Self-checking bench of the datapath FIFO and ALU block
`timescale 1ns/1ps
`default_nettype none
module dpf_datapath_bench
  import dpf_pkg::*;
();
  logic        core_clk, reset_n, read, write, waitrequest, irq;
  logic        carryOut, nbrCarry, cyQ;
  logic [7:0]  address, aluResult, a, b;
  logic [31:0] writedata, readdata;
  logic [15:0] lf;
  logic [63:0] ev;
  logic [63:0] expQ[$];
  logic [7:0]  fb[4];
  logic [1:0]  blkS, busS;
  dpf_route_s  rt, rtIn;
  int          errCount, nTests, cyc;
  // ------------------------------------------------
  // Instances and clock
  // ------------------------------------------------
  dpf_datapath #(.FIFO_DEPTH(4)) dut_u (.core_clk(core_clk),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .route(rtIn), .fifoBlockSideStatus(blkS), .fifoBusSideStatus(busS),
    .carryOut(carryOut), .aluResult(aluResult), .irq(irq));
  dpf_nbr_model nbr_u (.core_clk(core_clk), .reset_n(reset_n),
    .carryQ(nbrCarry));
  always_comb begin
    rtIn = rt;
    rtIn.carryChained = nbrCarry;
  end
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic endSim;
    $display("Checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    nTests++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Avalon master; a read notes its expected data and mask
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, e, m);
    @(posedge core_clk);
    address <= ad;
    writedata <= d;
    write <= w;
    read <= !w;
    if (!w) expQ.push_back({m, e});
    // No local limit: only the bench timeout ends a hung wait
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // One ALU cycle on acc0/acc1 with the expected carry worked out here
  task automatic op(input logic [2:0] f, input logic [1:0] cs,
                    input logic u);
    logic [8:0] s;
    logic [7:0] bb, r;
    logic ci, c, ri;
    lf = nxt(lf);
    ri = lf[1];
    @(posedge core_clk);
    rt.aluFunc <= dpf_alu_e'(f);
    rt.ciUseB <= u;
    rt.carryRouted <= ri;
    #1;
    bb = (f == 3'd1) ? 8'h00 : (f == 3'd2) ? 8'hFF : (f == 3'd4) ? ~b : b;
    ci = (cs == 2'd0) ? (f == 3'd1 || f == 3'd4) : (cs == 2'd2) ? ri :
         (cs == 2'd3) ? nbrCarry : cyQ;
    // selected carry is active low for DEC and SUB
    if (cs != 2'd0 && (f == 3'd2 || f == 3'd4)) ci = !ci;
    s = {1'b0, a} + {1'b0, bb} + 9'(ci);
    r = (f == 3'd0) ? a : (f == 3'd5) ? a ^ b : (f == 3'd6) ? a & b :
        (f == 3'd7) ? a | b : s[7:0];
    c = (f == 3'd1 || f == 3'd3) ? s[8] :
        (f == 3'd2 || f == 3'd4) ? !s[8] : 1'b0;
    @(posedge core_clk);
    #1;
    chk("aluResult", 32'(aluResult), 32'(r));
    chk("carryOut", 32'(carryOut), 32'(c));
    cyQ = c;
  endtask
  task automatic accs(input logic [7:0] x, y);
    a = x;
    b = y;
    bus(1, REG_ACC0_OFS, {24'h0, x}, 0, 0);
    bus(1, REG_ACC1_OFS, {24'h0, y}, 0, 0);
  endtask
  // Watcher takes the oldest note at each completed read
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      errCount++;
      endSim();
    end
    if (reset_n && read && waitrequest === 1'b0) begin
      ev = expQ.pop_front();
      chk("readdata", readdata & ev[63:32], ev[31:0]);
    end
  end
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    {reset_n, read, write, address, writedata, rt, cyQ} = '0;
    lf = 16'd62917;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    bus(0, REG_CONFIG_OFS, 0, CFG_RST, '1);
    bus(0, 8'h24, 0, 0, '1);
    // Every function under default, routed and chained carry
    for (int cs = 0; cs < 4; cs++) if (cs != 1) begin
      bus(1, REG_CONFIG_OFS, CFG_RST | 32'h1000 | (32'(cs) << 10), 0, 0);
      for (int f = 0; f < 8; f++) begin
        lf = nxt(lf);
        accs(lf[7:0], lf[15:8]);
        op(3'(f), 2'(cs), 1'b0);
      end
    end
    // Registered carry feeds the next add
    bus(1, REG_CONFIG_OFS, CFG_RST | 32'h1000, 0, 0);
    accs(8'hFF, 8'h01);
    op(3'd3, 2'd0, 1'b0);
    op(3'd3, 2'd1, 1'b1);
    op(3'd0, 2'd0, 1'b0);
    // Carry interrupt: raise, mask, clear
    bus(1, REG_IRQSTA_OFS, 32'h1F, 0, 0);
    op(3'd1, 2'd0, 1'b0);
    op(3'd0, 2'd0, 1'b0);
    bus(0, REG_IRQSTA_OFS, 0, 32'h10, 32'h10);
    chk("irq", 32'(irq), 0);
    bus(1, REG_IRQMSK_OFS, 32'h10, 0, 0);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'(irq), 1);
    bus(1, REG_IRQSTA_OFS, 32'h10, 0, 0);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'(irq), 0);
    // Dynamic FIFO0, external side: fill to full, drain in order
    // internal-side write source is accumulator 0; the external side takes bus writes
    bus(1, REG_CONFIG_OFS, CFG_RST | 32'h14, 0, 0);
    rt.dataRegLoad <= 2'b01;
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      fb[i] = lf[7:0];
      bus(1, REG_FIFO0_OFS, {24'h0, fb[i]}, 0, 0);
    end
    bus(0, REG_STATUS_OFS, 0, 32'h5, 32'h5);
    chk("fifoStat", 32'({blkS[0], busS[0]}), 32'h3);
    for (int i = 0; i < 4; i++) begin
      // One byte left: not empty at level 0, below half at level 1
      if (i == 3) begin
        bus(0, REG_STATUS_OFS, 0, 32'h4, 32'h5);
        bus(1, REG_CONFIG_OFS, CFG_RST | 32'h114, 0, 0);
        bus(0, REG_STATUS_OFS, 0, 0, 32'h5);
      end
      bus(0, REG_FIFO0_OFS, 0, 32'(fb[i]), 32'hFF);
    end
    bus(0, REG_STATUS_OFS, 0, 0, 32'h5);
    // Internal side: push acc0, pop back into acc0
    bus(1, REG_ACC0_OFS, 32'h5A, 0, 0);
    rt.dataRegLoad <= 2'b00;
    rt.fifoLoad <= 2'b01;
    @(posedge core_clk);
    rt.fifoLoad <= 2'b00;
    bus(1, REG_ACC0_OFS, 32'h33, 0, 0);
    rt.fifoToAcc <= 2'b01;
    @(posedge core_clk);
    rt.fifoToAcc <= 2'b00;
    bus(0, REG_ACC0_OFS, 0, 32'h5A, 32'hFF);
    rt.dataRegLoad <= 2'b01;
    bus(0, REG_DREG_OFS, 0, 0, 32'hFF);
    // Let the watcher take the last read before the verdict
    repeat (2) @(posedge core_clk);
    chk("pending", 32'(expQ.size()), 0);
    endSim();
  end
endmodule
`default_nettype wire
